// >>> crl_pkg.sv
// shared constants and types for the correlator configuration and reference load block
package crl_pkg;

    localparam int          STAGES      = 8;
    localparam int          ROW_LEN     = 32;
    localparam int          ARRAY_BITS  = 256;
    localparam int          SUM_W       = 6;
    localparam int          SCORE_W     = 16;
    localparam int          BUF_DEPTH   = 2;

    // register select codes
    localparam logic [2:0]  SEL_ARRAY   = 3'h0;
    localparam logic [2:0]  SEL_CFG     = 3'h1;
    localparam logic [2:0]  SEL_OFFA_HI = 3'h2;
    localparam logic [2:0]  SEL_OFFA_LO = 3'h3;
    localparam logic [2:0]  SEL_DELAY   = 3'h4;
    localparam logic [2:0]  SEL_OFFB_HI = 3'h5;
    localparam logic [2:0]  SEL_OFFB_LO = 3'h6;

    // window configuration codes
    localparam logic [7:0]  CFG_1X256   = 8'h00;
    localparam logic [7:0]  CFG_8X32    = 8'h0F;
    localparam logic [7:0]  CFG_DUAL    = 8'h12;
    localparam logic [7:0]  CFG_RESET   = 8'h00;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;

    // loads needed to fill the arrays per mode
    localparam logic [8:0]  LOADS_1X256 = 9'h100;
    localparam logic [8:0]  LOADS_8X32  = 9'h020;
    localparam logic [8:0]  LOADS_DUAL  = 9'h040;
    localparam logic [8:0]  ARRAY_LOADS = 9'h100;

    // row lanes: group mask for stage heads, index from low config bits
    localparam logic [2:0]  HEAD_MASK   = 3'h7;
    localparam logic [7:0]  WT_UNIT     = 8'h01;
    localparam logic [7:0]  WT_DOUBLE   = 8'h02;
    // per-stage weights of the 8-bit data mode, stage 7 first
    localparam logic [7:0][7:0] WT_BIN  = {8'h80, 8'h08, 8'h20, 8'h04,
                                           8'h40, 8'h02, 8'h10, 8'h01};
    localparam int          DUAL_SPLIT  = 4;

    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] cdat;
        logic [7:0] rdat;
        logic       rld_n;
        logic       cld_n;
        logic       xfr_n;
    } crl_pins_t;

    localparam crl_pins_t PINS_RESET = '{sel: 3'h0, cdat: 8'h00, rdat: 8'h00,
                                         rld_n: 1'b1, cld_n: 1'b1, xfr_n: 1'b1};

    typedef logic [STAGES-1:0][SUM_W-1:0] crl_sums_t;

    typedef struct packed {
        logic [SCORE_W-1:0] a;
        logic [SCORE_W-1:0] b;
    } crl_score_t;

endpackage

// >>> crl_buf.sv
// two-entry valid/ready buffer for correlation scores
`timescale 1ns/1ns
module crl_buf #(
    parameter int W = 32,
    parameter int D = 2
) (
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
        logic [PW:0]         cnt;
    } crl_buf_st_t;

    crl_buf_st_t st_r;
    crl_buf_st_t st_nxt;
    logic        push;
    logic        pop;

    function automatic logic [PW-1:0] bump(logic [PW-1:0] p);
        bump = (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready  = (st_r.cnt != (PW + 1)'(D));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp           = bump(st_r.wp);
        end
        if (pop)
            st_nxt.rp = bump(st_r.rp);
        if (push && !pop)
            st_nxt.cnt = (PW + 1)'(st_r.cnt + 1'b1);
        else if (pop && !push)
            st_nxt.cnt = (PW + 1)'(st_r.cnt - 1'b1);
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // a stall keeps the head word in place
    stall_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        out_valid && !out_ready |=> out_valid && out_data == $past(out_data))
        else $error("buffered word changed while stalled");
endmodule // crl_buf

// >>> crl_top.sv
// configuration registers, reference and mask preload and transfer of the correlation array
//
// Summary of operation
// R1: select 000 loads reference and mask together
// R2: 1x256 loads serially on bit 7, 256 strobes
// R3: transfer low pulse copies preload into active
// R4: 8x32 loads eight bits, 32 strobes
// R5: dual 2x64 fills arrays in 64 strobes
// R6: host sets delay zero in dual mode
// R7: config 00000000 selects 1x256 equal weighting
// R8: config 00001111 selects 8x32 binary weighting
// R9: config 00010010 forms two 2-bit correlators
// R10: offset A from upper 010, lower 011
// R11: programmable delay written at address 100
// R12: offset B at 101 and 110, optional
// R13: host may load in 8x32, then reconfigure
// R14: 8-bit mode score sums confidence bytes
// R15: reference strobe rising edge captures reference bus
// R16: host leaves a cycle before transfer
// R17: other addresses latch control byte on rise; the code latches nothing at 111
`timescale 1ns/1ns
module crl_top (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic [2:0]         register_select,
    input  wire logic [7:0]         control_data_bus,
    input  wire logic [7:0]         reference_data_bus,
    input  wire logic               reference_load_strobe_n,
    input  wire logic               control_load_strobe_n,
    input  wire logic               transfer_strobe_n,
    input  wire crl_pkg::crl_sums_t stage_sum_outputs,
    input  wire logic               sums_valid,
    output logic                    sums_ready,
    output logic [7:0]              window_cfg,
    output logic [15:0]             offset_a,
    output logic [15:0]             offset_b,
    output logic [7:0]              sample_delay,
    output logic                    dual_mode,
    output logic [255:0]            ref_active,
    output logic [255:0]            mask_active,
    output logic                    ref_filled,
    output logic                    mask_filled,
    output crl_pkg::crl_score_t     score,
    output logic                    score_valid,
    input  wire logic               score_ready
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        crl_pkg::crl_pins_t p1;
        crl_pkg::crl_pins_t p2;
        crl_pkg::crl_pins_t p3;
        logic               rld_lvl;
        logic               cld_lvl;
        logic               xfr_lvl;
        logic [7:0]         cfg;
        logic [7:0]         offa_hi;
        logic [7:0]         offa_lo;
        logic [7:0]         dly;
        logic [7:0]         offb_hi;
        logic [7:0]         offb_lo;
        logic [255:0]       ref_pre;
        logic [255:0]       mask_pre;
        logic [255:0]       ref_act;
        logic [255:0]       mask_act;
        logic [8:0]         ref_cnt;
        logic [8:0]         mask_cnt;
    } crl_state_t;

    localparam crl_state_t ST_RESET = '{
        p1: crl_pkg::PINS_RESET, p2: crl_pkg::PINS_RESET, p3: crl_pkg::PINS_RESET,
        rld_lvl: 1'b1, cld_lvl: 1'b1, xfr_lvl: 1'b1,
        cfg: crl_pkg::CFG_RESET, offa_hi: crl_pkg::BYTE_RESET,
        offa_lo: crl_pkg::BYTE_RESET, dly: crl_pkg::BYTE_RESET,
        offb_hi: crl_pkg::BYTE_RESET, offb_lo: crl_pkg::BYTE_RESET,
        ref_pre: '0, mask_pre: '0, ref_act: '0, mask_act: '0,
        ref_cnt: '0, mask_cnt: '0};

    crl_state_t          st_r;
    crl_state_t          st_nxt;
    crl_pkg::crl_pins_t  pins_in;
    crl_pkg::crl_score_t score_in;
    logic                rld_rise;
    logic                cld_rise;
    logic                xfr_fall;
    logic                arr_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // true when stage r takes its bit straight from a data pin
    function automatic logic is_head(logic [7:0] cfg, logic [2:0] r);
        logic [2:0] gm;
        gm      = crl_pkg::HEAD_MASK >> cfg[1:0];
        is_head = ((r & gm) == gm);
    endfunction

    // one load strobe: each row shifts toward bit 0, heads fed from pins
    function automatic logic [255:0] shift_in(logic [255:0] a, logic [7:0] pins,
                                              logic [7:0] cfg);
        logic [255:0] n;
        logic         b;
        n = a;
        for (int r = 0; r < crl_pkg::STAGES; r++)
        begin
            b = is_head(cfg, 3'(r)) ? pins[r]
                : a[((r + 1) % crl_pkg::STAGES) * crl_pkg::ROW_LEN];
            n[r*crl_pkg::ROW_LEN +: crl_pkg::ROW_LEN] =
                {b, a[r*crl_pkg::ROW_LEN+1 +: crl_pkg::ROW_LEN-1]};
        end
        shift_in = n;
    endfunction

    function automatic logic [8:0] loads_needed(logic [7:0] cfg);
        loads_needed = crl_pkg::ARRAY_LOADS >> cfg[1:0];
    endfunction

    function automatic logic [8:0] count_up(logic [8:0] c);
        count_up = (c == crl_pkg::ARRAY_LOADS) ? c : 9'(c + 1'b1);
    endfunction

    function automatic logic [7:0] weight(logic [7:0] cfg, logic [2:0] r);
        if (cfg == crl_pkg::CFG_8X32)
            weight = crl_pkg::WT_BIN[r];
        else if (cfg == crl_pkg::CFG_DUAL)
            weight = r[1] ? crl_pkg::WT_DOUBLE : crl_pkg::WT_UNIT;
        else
            weight = crl_pkg::WT_UNIT;
    endfunction

    function automatic logic [15:0] wsum(crl_pkg::crl_sums_t s, logic [7:0] cfg,
                                         int lo, int hi);
        logic [15:0] acc;
        acc = '0;
        for (int r = 0; r < crl_pkg::STAGES; r++)
            if (r >= lo && r <= hi)
                acc = 16'(acc + 16'(s[r]) * 16'(weight(cfg, 3'(r))));
        wsum = acc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pins are asynchronous to mclk; data lanes ride the same three stages
    assign pins_in = '{sel: register_select, cdat: control_data_bus,
                       rdat: reference_data_bus, rld_n: reference_load_strobe_n,
                       cld_n: control_load_strobe_n, xfr_n: transfer_strobe_n};

    assign rld_rise = (st_r.p2.rld_n == st_r.p3.rld_n) && st_r.p3.rld_n && !st_r.rld_lvl; // R15
    assign cld_rise = (st_r.p2.cld_n == st_r.p3.cld_n) && st_r.p3.cld_n && !st_r.cld_lvl;
    assign xfr_fall = (st_r.p2.xfr_n == st_r.p3.xfr_n) && !st_r.p3.xfr_n && st_r.xfr_lvl; // R3
    assign arr_sel  = (st_r.p3.sel == crl_pkg::SEL_ARRAY); // R1

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.p1 = pins_in;
        st_nxt.p2 = st_r.p1;
        st_nxt.p3 = st_r.p2;
        if (st_r.p2.rld_n == st_r.p3.rld_n)
            st_nxt.rld_lvl = st_r.p3.rld_n;
        if (st_r.p2.cld_n == st_r.p3.cld_n)
            st_nxt.cld_lvl = st_r.p3.cld_n;
        if (st_r.p2.xfr_n == st_r.p3.xfr_n)
            st_nxt.xfr_lvl = st_r.p3.xfr_n;

        // mode-dependent lanes: serial, 8 rows, or 4 rows in dual
        if (rld_rise && arr_sel)
        begin
            st_nxt.ref_pre = shift_in(st_r.ref_pre, st_r.p3.rdat, st_r.cfg); // R1 R2 R4 R5 R9 R15
            st_nxt.ref_cnt = count_up(st_r.ref_cnt); // R2 R4 R5
        end
        if (cld_rise && arr_sel)
        begin
            st_nxt.mask_pre = shift_in(st_r.mask_pre, st_r.p3.cdat, st_r.cfg); // R1 R2 R4 R5
            st_nxt.mask_cnt = count_up(st_r.mask_cnt); // R2 R4 R5
        end
        if (cld_rise && !arr_sel)
        begin
            case (st_r.p3.sel) // R17
                crl_pkg::SEL_CFG:     st_nxt.cfg     = st_r.p3.cdat; // R7 R8 R9
                crl_pkg::SEL_OFFA_HI: st_nxt.offa_hi = st_r.p3.cdat; // R10
                crl_pkg::SEL_OFFA_LO: st_nxt.offa_lo = st_r.p3.cdat; // R10
                crl_pkg::SEL_DELAY:   st_nxt.dly     = st_r.p3.cdat; // R11
                crl_pkg::SEL_OFFB_HI: st_nxt.offb_hi = st_r.p3.cdat; // R12
                crl_pkg::SEL_OFFB_LO: st_nxt.offb_lo = st_r.p3.cdat; // R12
                default:              st_nxt.cfg     = st_r.cfg;
            endcase
        end
        // a load in the transfer cycle misses it; the host spaces them apart
        if (xfr_fall)
        begin
            st_nxt.ref_act  = st_r.ref_pre; // R3 R16
            st_nxt.mask_act = st_r.mask_pre; // R3
            // a load landing with the transfer still counts toward the next fill
            st_nxt.ref_cnt  = 9'(rld_rise && arr_sel);
            st_nxt.mask_cnt = 9'(cld_rise && arr_sel);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= ST_RESET;
        else
            st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign window_cfg   = st_r.cfg;
    assign offset_a     = {st_r.offa_hi, st_r.offa_lo}; // R10
    assign offset_b     = {st_r.offb_hi, st_r.offb_lo}; // R12
    assign sample_delay = st_r.dly; // R11
    assign dual_mode    = (st_r.cfg == crl_pkg::CFG_DUAL); // R9
    assign ref_active   = st_r.ref_act;
    assign mask_active  = st_r.mask_act;
    assign ref_filled   = (st_r.ref_cnt >= loads_needed(st_r.cfg)); // R2 R4 R5
    assign mask_filled  = (st_r.mask_cnt >= loads_needed(st_r.cfg));

    // dual splits the eight stage sums into two scores
    always_comb
    begin
        score_in = '0;
        if (dual_mode)
        begin
            score_in.a = wsum(stage_sum_outputs, st_r.cfg, crl_pkg::DUAL_SPLIT,
                              crl_pkg::STAGES - 1); // R9
            score_in.b = wsum(stage_sum_outputs, st_r.cfg, 0,
                              crl_pkg::DUAL_SPLIT - 1); // R9
        end
        else
            score_in.a = wsum(stage_sum_outputs, st_r.cfg, 0, crl_pkg::STAGES - 1); // R7 R8 R14
    end

    crl_buf #(
        .W ($bits(crl_pkg::crl_score_t)),
        .D (crl_pkg::BUF_DEPTH)
    ) u_buf (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (sums_valid),
        .in_ready  (sums_ready),
        .in_data   (score_in),
        .out_valid (score_valid),
        .out_ready (score_ready),
        .out_data  (score)
    );

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    xfer_copy_a: assert property (xfr_fall |=> ref_active == $past(st_r.ref_pre) // R3
        && mask_active == $past(st_r.mask_pre))
        else $error("transfer did not copy preload");
    serial_load_a: assert property (rld_rise && arr_sel && st_r.cfg == crl_pkg::CFG_1X256 // R2
        |=> st_r.ref_pre == {$past(st_r.p3.rdat[7]), $past(st_r.ref_pre[255:1])})
        else $error("serial reference load wrong");
    wide_load_a: assert property (cld_rise && arr_sel && st_r.cfg == crl_pkg::CFG_8X32 // R4
        |=> st_r.mask_pre[255] == $past(st_r.p3.cdat[7])
        && st_r.mask_pre[31] == $past(st_r.p3.cdat[0])
        && st_r.mask_pre[62:32] == $past(st_r.mask_pre[63:33]))
        else $error("eight lane mask load wrong");
    dual_load_a: assert property (rld_rise && arr_sel && dual_mode // R9
        |=> st_r.ref_pre[223] == $past(st_r.ref_pre[224])
        && st_r.ref_pre[191] == $past(st_r.p3.rdat[5])
        && st_r.ref_pre[63] == $past(st_r.p3.rdat[1]))
        else $error("dual reference lanes wrong");
    cfg_write_a: assert property (cld_rise && st_r.p3.sel == crl_pkg::SEL_CFG // R17
        |=> window_cfg == $past(st_r.p3.cdat) && $stable(offset_a))
        else $error("config write lost");
    offset_a_a: assert property (cld_rise && st_r.p3.sel == crl_pkg::SEL_OFFA_LO // R10
        |=> offset_a[7:0] == $past(st_r.p3.cdat) && offset_a[15:8] == $past(offset_a[15:8]))
        else $error("offset A low byte wrong");
    delay_wr_a: assert property (cld_rise && st_r.p3.sel == crl_pkg::SEL_DELAY // R11
        |=> sample_delay == $past(st_r.p3.cdat))
        else $error("delay write lost");
    offset_b_a: assert property (cld_rise && st_r.p3.sel == crl_pkg::SEL_OFFB_HI // R12
        |=> offset_b[15:8] == $past(st_r.p3.cdat))
        else $error("offset B high byte wrong");
    no_ref_a: assert property (rld_rise && !arr_sel |=> $stable(st_r.ref_pre)) // R1
        else $error("reference moved off array select");
    bin_score_a: assert property (st_r.cfg == crl_pkg::CFG_8X32 // R8
        |-> score_in.a == 16'(stage_sum_outputs[7]) * 16'h0080
            + 16'(stage_sum_outputs[3]) * 16'h0040 + 16'(stage_sum_outputs[5]) * 16'h0020
            + 16'(stage_sum_outputs[1]) * 16'h0010 + 16'(stage_sum_outputs[6]) * 16'h0008
            + 16'(stage_sum_outputs[4]) * 16'h0004 + 16'(stage_sum_outputs[2]) * 16'h0002
            + 16'(stage_sum_outputs[0]))
        else $error("binary weighted score wrong");
    fill_cnt_a: assert property (st_r.cfg == crl_pkg::CFG_DUAL // R5
        |-> ref_filled == (st_r.ref_cnt >= crl_pkg::LOADS_DUAL))
        else $error("dual fill flag wrong");
    offa_hi_a: assert property (cld_rise && st_r.p3.sel == crl_pkg::SEL_OFFA_HI // R10
        |=> offset_a[15:8] == $past(st_r.p3.cdat) && offset_a[7:0] == $past(offset_a[7:0]))
        else $error("offset A high byte wrong");
    mask_serial_a: assert property (cld_rise && arr_sel && st_r.cfg == crl_pkg::CFG_1X256 // R2
        |=> st_r.mask_pre == {$past(st_r.p3.cdat[7]), $past(st_r.mask_pre[255:1])})
        else $error("serial mask load wrong");
    sel_unused_a: assert property (cld_rise && (&st_r.p3.sel) // R17
        |=> $stable(window_cfg) && $stable(offset_a) && $stable(offset_b) && $stable(sample_delay))
        else $error("unused select changed a register");
    fill_wide_a: assert property (st_r.cfg == crl_pkg::CFG_8X32 // R4
        |-> mask_filled == (st_r.mask_cnt >= crl_pkg::LOADS_8X32))
        else $error("eight lane fill flag wrong");
    equal_score_a: assert property (st_r.cfg == crl_pkg::CFG_1X256 // R7
        |-> score_in.b == '0 && score_in.a == 16'(stage_sum_outputs[7])
            + 16'(stage_sum_outputs[6]) + 16'(stage_sum_outputs[5]) + 16'(stage_sum_outputs[4])
            + 16'(stage_sum_outputs[3]) + 16'(stage_sum_outputs[2]) + 16'(stage_sum_outputs[1])
            + 16'(stage_sum_outputs[0]))
        else $error("equal weighted score wrong");
    dual_score_a: assert property (dual_mode // R9
        |-> score_in.a == 16'(stage_sum_outputs[7]) * 16'h0002
            + 16'(stage_sum_outputs[6]) * 16'h0002 + 16'(stage_sum_outputs[5])
            + 16'(stage_sum_outputs[4]) && score_in.b == 16'(stage_sum_outputs[3]) * 16'h0002
            + 16'(stage_sum_outputs[2]) * 16'h0002 + 16'(stage_sum_outputs[1])
            + 16'(stage_sum_outputs[0]))
        else $error("dual scores wrong");
endmodule // crl_top

// >>> crl_host.sv
// host model driving the load, select and transfer pins of the correlator
`timescale 1ns/1ns
module crl_host (
    input  wire logic          mclk,
    output crl_pkg::crl_pins_t pins
);
    // strobes held well past the three-flop filter of the device
    localparam int HOLD = 5;

    initial pins = crl_pkg::PINS_RESET;

    ////////////////////////////////////////////////////////////////////
    task automatic pulse(input logic r, input logic c);
        repeat (HOLD) @(posedge mclk);
        pins.rld_n <= ~r;
        pins.cld_n <= ~c;
        repeat (HOLD) @(posedge mclk);
        pins.rld_n <= 1'b1;
        pins.cld_n <= 1'b1;
        repeat (HOLD) @(posedge mclk);
        // hold time over: released buses show the inverse, not the last byte
        pins.cdat <= ~pins.cdat;
        pins.rdat <= ~pins.rdat;
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge mclk);
        pins.sel  <= s;
        pins.cdat <= d;
        pulse(1'b0, 1'b1);
    endtask

    // reference and mask strobed together
    task automatic ld(input logic [7:0] r, input logic [7:0] m);
        @(posedge mclk);
        pins.sel  <= 3'h0;
        pins.rdat <= r;
        pins.cdat <= m;
        pulse(1'b1, 1'b1);
    endtask

    // last strobe rise lies HOLD+1 cycles back, so no load lands in the transfer cycle
    task automatic xfr();
        @(posedge mclk);
        pins.xfr_n <= 1'b0;
        repeat (HOLD) @(posedge mclk);
        pins.xfr_n <= 1'b1;
        repeat (HOLD) @(posedge mclk);
    endtask
endmodule // crl_host

// >>> tb_crl_top.sv
// self-checking testbench of the correlator configuration and reference load block
`timescale 1ns/1ns
module tb_crl_top;
    logic                mclk;
    logic                sys_rst;
    crl_pkg::crl_pins_t  pins;
    crl_pkg::crl_sums_t  stage_sum_outputs;
    logic                sums_valid;
    logic                sums_ready;
    logic                score_ready;
    logic                score_valid;
    crl_pkg::crl_score_t score;
    logic [7:0]          window_cfg;
    logic [7:0]          sample_delay;
    logic [15:0]         offset_a;
    logic [15:0]         offset_b;
    logic                dual_mode;
    logic [255:0]        ref_active;
    logic [255:0]        mask_active;
    logic                ref_filled;
    logic                mask_filled;
    logic [255:0]        m_ref;
    logic [255:0]        m_msk;
    logic [7:0]          mcfg;
    logic [7:0]          mr [8];
    logic [31:0]         q [$];
    int                  err_count;
    int                  checks_done;

    crl_host u_crl_host (.mclk(mclk), .pins(pins));

    crl_top u_crl_top (
        .mclk(mclk), .sys_rst(sys_rst), .register_select(pins.sel),
        .control_data_bus(pins.cdat), .reference_data_bus(pins.rdat),
        .reference_load_strobe_n(pins.rld_n), .control_load_strobe_n(pins.cld_n),
        .transfer_strobe_n(pins.xfr_n), .stage_sum_outputs(stage_sum_outputs),
        .sums_valid(sums_valid), .sums_ready(sums_ready), .window_cfg(window_cfg),
        .offset_a(offset_a), .offset_b(offset_b), .sample_delay(sample_delay),
        .dual_mode(dual_mode), .ref_active(ref_active), .mask_active(mask_active),
        .ref_filled(ref_filled), .mask_filled(mask_filled), .score(score),
        .score_valid(score_valid), .score_ready(score_ready)
    );

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // shift chain: head stages take their lane, others the stage above
    function automatic logic [255:0] shl(input logic [255:0] v, input logic [7:0] d,
                                         input logic [1:0] c);
        logic [255:0] n;
        logic [2:0]   mk;
        mk = 3'h7 >> c;
        n  = v >> 1;
        for (int r = 0; r < 8; r++)
            n[r*32+31] = ((3'(r) & mk) == mk) ? d[r] : v[(r*32+32) % 256];
        return n;
    endfunction

    function automatic logic [31:0] exp_score(input logic [7:0] c,
                                              input crl_pkg::crl_sums_t s);
        int w [8];
        int a;
        int b;
        a = 0;
        b = 0;
        w = '{1, 1, 1, 1, 1, 1, 1, 1};
        if (c == 8'h0F)
            w = '{1, 16, 2, 64, 4, 32, 8, 128};
        if (c == 8'h12)
            w = '{1, 1, 2, 2, 1, 1, 2, 2};
        for (int r = 0; r < 8; r++)
            if (c == 8'h12 && r < 4)
                b += w[r] * int'(s[r]);
            else
                a += w[r] * int'(s[r]);
        return {a[15:0], b[15:0]};
    endfunction

    always @(posedge mclk)
    begin
        if (!sys_rst && sums_valid && sums_ready)
            q.push_back(exp_score(mcfg, stage_sum_outputs));
        if (!sys_rst && score_valid && score_ready)
            chk("score", (q.size() > 0) ? q.pop_front() : 'x, score);
    end

    // buffer filled until it refuses, then random stalls of the sink
    task automatic stream();
        for (int i = 0; i < 48; i++)
        begin
            @(posedge mclk);
            sums_valid        <= (i < 7) ? 1'b1 : 1'($urandom());
            score_ready       <= (i < 7) ? 1'b0 : ($urandom() % 3 != 0);
            stage_sum_outputs <= crl_pkg::crl_sums_t'({$urandom(), $urandom()});
            if (i == 6)
            begin
                @(negedge mclk);
                chk("sums_ready", 1'b0, sums_ready);
            end
        end
        @(posedge mclk);
        sums_valid  <= 1'b0;
        score_ready <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk("score_left", 0, q.size());
        chk("score_valid", 1'b0, score_valid);
    endtask

    task automatic fill(input logic [7:0] c);
        logic [7:0] rb;
        logic [7:0] mb;
        int         n;
        u_crl_host.wr(3'h1, c);
        mcfg = c;
        if (c == 8'h12)
            u_crl_host.wr(3'h4, 8'h00);
        n = 256 >> c[1:0];
        for (int i = 0; i < n; i++)
        begin
            rb = 8'($urandom());
            mb = 8'($urandom());
            u_crl_host.ld(rb, mb);
            m_ref = shl(m_ref, rb, c[1:0]);
            m_msk = shl(m_msk, mb, c[1:0]);
            if (i == n - 2)
            begin
                @(negedge mclk);
                chk("ref_filled", 1'b0, ref_filled);
            end
        end
        @(negedge mclk);
        chk("ref_filled", 1'b1, ref_filled);
        chk("mask_filled", 1'b1, mask_filled);
    endtask

    task automatic commit();
        u_crl_host.xfr();
        @(negedge mclk);
        chk("ref_active", m_ref, ref_active);
        chk("mask_active", m_msk, mask_active);
        chk("ref_filled", 1'b0, ref_filled);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] cl [4];
        logic [7:0] b;
        cl = '{8'h00, 8'h0F, 8'h12, 8'h01};
        err_count = 0;
        checks_done = 0;
        m_ref = '0;
        m_msk = '0;
        mcfg = 8'h00;
        void'($urandom(32'hA37B));
        sys_rst = 1'b1;
        sums_valid = 1'b0;
        score_ready = 1'b1;
        stage_sum_outputs = '0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        chk("window_cfg", 8'h00, window_cfg);
        chk("sums_ready", 1'b1, sums_ready);
        chk("score_valid", 1'b0, score_valid);
        for (int s = 1; s < 8; s++)
        begin
            b = 8'($urandom());
            u_crl_host.wr(3'(s), b);
            if (s < 7)
                mr[s] = b;
        end
        @(negedge mclk);
        chk("window_cfg", mr[1], window_cfg);
        chk("offset_a", {mr[2], mr[3]}, offset_a);
        chk("sample_delay", mr[4], sample_delay);
        chk("offset_b", {mr[5], mr[6]}, offset_b);
        chk("dual_mode", mr[1] == 8'h12, dual_mode);
        u_crl_host.wr(3'h2, 8'h00);
        u_crl_host.wr(3'h3, 8'h10);
        u_crl_host.pulse(1'b1, 1'b0);
        @(negedge mclk);
        chk("offset_a", 16'h0010, offset_a);
        foreach (cl[k])
        begin
            fill(cl[k]);
            chk("window_cfg", cl[k], window_cfg);
            chk("dual_mode", cl[k] == 8'h12, dual_mode);
            commit();
            stream();
        end
        // quick eight-lane load, then back to one lane before the transfer
        fill(8'h0F);
        u_crl_host.wr(3'h1, 8'h00);
        mcfg = 8'h00;
        commit();
        results();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        results();
    end
endmodule // tb_crl_top
